// File: src/drs_pkg.sv
package drs_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_MHZ = 200;
	// decision period in ns; terminals and keys are judged once per period
	localparam int DECIDE_NS = 1000;
	localparam int DECIDE_CYC = (DECIDE_NS * CLK_MHZ) / 1000;
	localparam int TICK_W = 8;

	// ----------------------------------------
	// drive modes, frequency sources, run disable
	// ----------------------------------------
	localparam logic [2:0] MODE_KEYPAD = 3'h0;
	localparam logic [2:0] MODE_TWO_WIRE = 3'h1;
	localparam logic [2:0] MODE_RUN_DIR = 3'h2;
	localparam logic [2:0] MODE_LINK = 3'h3;
	localparam logic [3:0] FSRC_KEYPAD = 4'h0;
	localparam logic [3:0] FSRC_BIPOLAR = 4'h2;
	localparam logic [1:0] RUN_DIS_FWD = 2'h1;
	localparam logic [1:0] RUN_DIS_REV = 2'h2;
	// keypad direction codes: F forward, r reverse
	localparam logic DIR_FWD = 1'h0;
	localparam logic DIR_REV = 1'h1;

	// ----------------------------------------
	// multi-function input codes
	// ----------------------------------------
	localparam logic [4:0] FUNC_FWD = 5'h00;
	localparam logic [4:0] FUNC_REV = 5'h01;
	localparam logic [4:0] FUNC_STEP0 = 5'h05;
	localparam logic [4:0] FUNC_STEP1 = 5'h06;
	localparam logic [4:0] FUNC_STEP2 = 5'h07;

	// ----------------------------------------
	// frequencies in 0.01 Hz units
	// ----------------------------------------
	localparam logic [15:0] FREQ_MAX = 16'h9C40;
	localparam logic [15:0] STEP_DEF [1:7] = '{16'h03E8, 16'h07D0, 16'h0BB8,
		16'h0BB8, 16'h09C4, 16'h07D0, 16'h05DC};

	// ----------------------------------------
	// serial link settings limits
	// ----------------------------------------
	localparam logic PROTO_MAX = 1'h1;
	localparam logic [7:0] STATION_MIN = 8'h01;
	localparam logic [7:0] STATION_MAX = 8'hFA;
	localparam logic [2:0] BAUD_MAX = 3'h4;
	localparam logic [2:0] BAUD_DEF = 3'h3;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef struct packed {
		logic [2:0] drive_mode;
		logic [3:0] freq_source;
		logic keypad_direction_select;
		logic [1:0] run_disable;
		logic power_up_autostart;
		logic restart_after_fault_clear;
		logic [7:0][4:0] input_function;
		logic link_protocol_select;
		logic [7:0] station_number;
		logic [2:0] link_baud_index;
	} drs_cfg_t;

	typedef struct packed {
		logic run;
		logic rev;
	} drs_link_cmd_t;

	typedef struct packed {
		logic run_press;
		logic stop_press;
	} drs_keys_t;

	typedef enum logic [1:0] {
		ST_STOP = 2'b00,
		ST_RUN = 2'b01,
		ST_TURN = 2'b10
	} drs_state_t;

endpackage

// File: src/drs_run_select.sv
module drs_run_select (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire drs_pkg::drs_cfg_t i_cfg,
	input wire logic [7:0] i_terminal,
	input wire drs_pkg::drs_keys_t i_local_keys,
	input wire drs_pkg::drs_keys_t i_remote_keys,
	input wire logic i_remote_present,
	input wire drs_pkg::drs_link_cmd_t i_link_cmd,
	input wire logic [15:0] i_freq_cmd,
	input wire logic [15:0] i_analog_freq,
	input wire logic i_bipolar_negative,
	input wire logic i_fault,
	input wire logic i_at_zero_speed,
	input wire logic i_step_wr,
	input wire logic [2:0] i_step_sel,
	input wire logic [15:0] i_step_data,
	output logic o_run,
	output logic o_reverse,
	output logic [15:0] o_freq_ref,
	output logic [2:0] o_step_index,
	output logic o_dir_blocked,
	output logic o_link_cfg_bad
);
	import drs_pkg::*;

	// ----------------------------------------
	// helpers
	// ----------------------------------------

	// any synchronised terminal whose function code matches
	function automatic logic func_on(input logic [7:0] term,
		input logic [7:0][4:0] fn, input logic [4:0] code);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (fn[i] == code && term[i]) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction

	// ----------------------------------------
	// terminal synchroniser
	// ----------------------------------------
	logic [7:0] term_meta, term_sync;

	// two flops; only term_sync is looked at
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			term_meta <= 8'h00;
			term_sync <= 8'h00;
		end else begin
			term_meta <= i_terminal;
			term_sync <= term_meta;
		end
	end

	// ----------------------------------------
	// decision tick
	// ----------------------------------------
	logic [TICK_W-1:0] tick_cnt;
	logic [TICK_W-1:0] next_tick_cnt;
	logic tick;
	logic next_tick;

	// one-cycle enable every decision period
	always_comb begin
		next_tick = 1'b0;
		next_tick_cnt = tick_cnt + 1'b1;
		if (tick_cnt == TICK_W'(DECIDE_CYC - 1)) begin
			next_tick_cnt = '0;
			next_tick = 1'b1;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tick_cnt <= '0;
			tick <= 1'b0;
		end else begin
			tick_cnt <= next_tick_cnt;
			tick <= next_tick;
		end
	end

	// ----------------------------------------
	// step frequency table
	// ----------------------------------------
	logic [15:0] step_freq [1:7];
	logic [15:0] next_step_data;

	// out-of-range writes clamp to the top of the range
	always_comb begin
		next_step_data = i_step_data;
		if (i_step_data > FREQ_MAX) begin
			next_step_data = FREQ_MAX;
		end
	end

	// a write to step zero is ignored: it has no entry
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int i = 1; i < 8; i++) begin
				step_freq[i] <= STEP_DEF[i];
			end
		end else if (i_step_wr && i_step_sel != 3'h0) begin
			step_freq[i_step_sel] <= next_step_data;
		end
	end

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	drs_keys_t keys;
	logic fwd_in, rev_in, term_run, link_bad;
	logic [2:0] step_idx;
	logic [15:0] ref_zero;

	always_comb begin
		// built-in keys are dead while the remote unit is present
		keys = i_remote_present ? i_remote_keys : i_local_keys;
		fwd_in = func_on(term_sync, i_cfg.input_function, FUNC_FWD);
		rev_in = func_on(term_sync, i_cfg.input_function, FUNC_REV);
		if (i_cfg.drive_mode == MODE_RUN_DIR) begin
			term_run = fwd_in;
		end else begin
			term_run = fwd_in ^ rev_in;
		end
		step_idx = {func_on(term_sync, i_cfg.input_function, FUNC_STEP2),
			func_on(term_sync, i_cfg.input_function, FUNC_STEP1),
			func_on(term_sync, i_cfg.input_function, FUNC_STEP0)};
		ref_zero = (i_cfg.freq_source == FSRC_KEYPAD) ?
			i_freq_cmd : i_analog_freq;
		link_bad = (i_cfg.link_protocol_select > PROTO_MAX)
			|| (i_cfg.station_number < STATION_MIN)
			|| (i_cfg.station_number > STATION_MAX)
			|| (i_cfg.link_baud_index > BAUD_MAX);
	end

	// ----------------------------------------
	// keypad latch and terminal arming
	// ----------------------------------------
	logic kp_run, next_kp_run, armed, next_armed, boot, next_boot, fault_d;

	// runs every cycle so no key pulse falls between ticks;
	// arming stops a terminal left on from starting the motor
	always_comb begin
		next_kp_run = kp_run;
		next_armed = armed;
		next_boot = boot;
		if (i_cfg.drive_mode != MODE_KEYPAD || i_fault || keys.stop_press) begin
			next_kp_run = 1'b0; // stop wins over run
		end else if (keys.run_press) begin
			next_kp_run = 1'b1;
		end
		if (boot) begin
			// wait one tick so the synchroniser holds real levels
			if (tick) begin
				next_boot = 1'b0;
				next_armed = i_cfg.power_up_autostart || !term_run;
			end
		end else if (i_fault) begin
			next_armed = 1'b0;
		end else if (fault_d) begin
			next_armed = i_cfg.restart_after_fault_clear || !term_run;
		end else if (!term_run) begin
			next_armed = 1'b1;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			kp_run <= 1'b0;
			armed <= 1'b0;
			boot <= 1'b1;
			fault_d <= 1'b0;
		end else begin
			kp_run <= next_kp_run;
			armed <= next_armed;
			boot <= next_boot;
			fault_d <= i_fault;
		end
	end

	// ----------------------------------------
	// run and direction request
	// ----------------------------------------
	logic want_run, want_rev, blocked, go;

	always_comb begin
		unique case (i_cfg.drive_mode)
			MODE_KEYPAD: begin
				want_run = kp_run;
				want_rev = (i_cfg.keypad_direction_select == DIR_REV);
			end
			MODE_TWO_WIRE: begin
				want_run = term_run && armed;
				want_rev = rev_in;
			end
			MODE_RUN_DIR: begin
				want_run = term_run && armed;
				want_rev = rev_in;
			end
			MODE_LINK: begin
				want_run = i_link_cmd.run && !link_bad;
				want_rev = i_link_cmd.rev;
			end
			default: begin
				want_run = 1'b0;
				want_rev = DIR_FWD;
			end
		endcase
		// negative bipolar input swaps whatever was commanded
		if (i_cfg.freq_source == FSRC_BIPOLAR) begin
			want_rev = want_rev ^ i_bipolar_negative;
		end
		blocked = want_run && (
			(i_cfg.run_disable == RUN_DIS_FWD && !want_rev) ||
			(i_cfg.run_disable == RUN_DIS_REV && want_rev));
		go = want_run && !blocked && !i_fault && !boot;
	end

	// ----------------------------------------
	// run state machine
	// ----------------------------------------
	drs_state_t state;
	drs_state_t next_state;
	logic next_run;
	logic next_reverse;

	// direction never flips while turning; it waits for zero speed
	always_comb begin
		next_state = state;
		next_run = o_run;
		next_reverse = o_reverse;
		if (tick) begin
			unique case (state)
				ST_STOP: begin
					next_run = 1'b0;
					if (go) begin
						next_run = 1'b1;
						next_reverse = want_rev;
						next_state = ST_RUN;
					end
				end
				ST_RUN: begin
					if (!go) begin
						next_run = 1'b0;
						next_state = ST_STOP;
					end else if (want_rev != o_reverse) begin
						next_run = 1'b0;
						next_state = ST_TURN;
					end
				end
				ST_TURN: begin
					next_run = 1'b0;
					if (i_at_zero_speed) begin
						if (go) begin
							next_run = 1'b1;
							next_reverse = want_rev;
							next_state = ST_RUN;
						end else begin
							next_state = ST_STOP;
						end
					end
				end
				default: begin
					next_run = 1'b0;
					next_state = ST_STOP;
				end
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= ST_STOP;
			o_run <= 1'b0;
			o_reverse <= DIR_FWD;
		end else begin
			state <= next_state;
			o_run <= next_run;
			o_reverse <= next_reverse;
		end
	end

	// ----------------------------------------
	// reference and status outputs
	// ----------------------------------------
	logic [15:0] next_freq_ref;

	// table lookup; index zero falls back to the ordinary reference
	always_comb begin
		if (step_idx == 3'h0) begin
			next_freq_ref = ref_zero;
		end else begin
			next_freq_ref = step_freq[step_idx];
		end
	end

	// refreshed once per tick so all outputs change together
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_freq_ref <= 16'h0000;
			o_step_index <= 3'h0;
			o_dir_blocked <= 1'b0;
			o_link_cfg_bad <= 1'b0;
		end else if (tick) begin
			o_freq_ref <= next_freq_ref;
			o_step_index <= step_idx;
			o_dir_blocked <= blocked;
			o_link_cfg_bad <= link_bad;
		end
	end

endmodule // drs_run_select

// File: verif/drs_run_select_asserts.sv
// ----------------------------------------
// port checks for run and step selection
// ----------------------------------------
module drs_run_select_asserts
	import drs_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire drs_pkg::drs_cfg_t i_cfg,
	input wire logic [15:0] i_freq_cmd,
	input wire logic i_fault,
	input wire logic o_run,
	input wire logic o_reverse,
	input wire logic [15:0] o_freq_ref,
	input wire logic [2:0] o_step_index,
	input wire logic o_dir_blocked,
	input wire logic o_link_cfg_bad
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [22:0] outs;
	logic [22:0] outs_q;
	logic [8:0] held;
	logic chg;
	logic bad;

	// any output move; outputs only move once per decision
	assign outs = {o_run, o_reverse, o_freq_ref, o_step_index, o_dir_blocked, o_link_cfg_bad};
	assign chg = outs != outs_q;
	assign bad = i_cfg.station_number < STATION_MIN || i_cfg.station_number > STATION_MAX
		|| i_cfg.link_baud_index > BAUD_MAX;

	// cycles since the last output move, saturating
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			outs_q <= '0;
			held <= '0;
		end else begin
			outs_q <= outs;
			held <= chg ? 9'h000 : held + {8'h00, held != 9'h1FF};
		end
	end

	default clocking @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_n);

	hold_spacing_a: assert property (chg |-> held >= 9'h0BE)
		else $error("outputs moved between decisions");
	fault_stop_a: assert property ($rose(i_fault) |-> ##[1:205] !o_run)
		else $error("fault did not stop run");
	block_no_run_a: assert property (o_dir_blocked |-> !o_run)
		else $error("blocked direction still running");
	link_bad_cause_a: assert property ($rose(o_link_cfg_bad) |-> $past(bad))
		else $error("link flag without bad setting");
	reset_quiet_a: assert property ($rose(i_rst_n) |-> !o_run [*8])
		else $error("run right after reset");
	freq_limit_a: assert property (o_freq_ref <= FREQ_MAX)
		else $error("reference above limit");
	step_zero_ref_a: assert property (chg && o_step_index == 3'h0
		&& $past(i_cfg.freq_source) == FSRC_KEYPAD |-> o_freq_ref == $past(i_freq_cmd))
		else $error("step zero reference wrong");
	dir_hold_a: assert property (o_run && $past(o_run) |-> $stable(o_reverse))
		else $error("direction flipped while running");

	cover property (o_run && o_reverse);
	cover property (o_dir_blocked);
	cover property (o_link_cfg_bad);
endmodule // drs_run_select_asserts

bind drs_run_select drs_run_select_asserts u_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
	.i_cfg(i_cfg), .i_freq_cmd(i_freq_cmd), .i_fault(i_fault), .o_run(o_run),
	.o_reverse(o_reverse), .o_freq_ref(o_freq_ref), .o_step_index(o_step_index),
	.o_dir_blocked(o_dir_blocked), .o_link_cfg_bad(o_link_cfg_bad));

// File: verif/drs_far_side.sv
// ----------------------------------------
// contacts, keypads and serial master
// ----------------------------------------
module drs_far_side
	import drs_pkg::*;
(
	input wire logic i_mclk,
	input wire logic [7:0] i_contacts,
	input wire drs_pkg::drs_keys_t i_local_req,
	input wire drs_pkg::drs_keys_t i_remote_req,
	input wire drs_pkg::drs_link_cmd_t i_link_req,
	output logic [7:0] o_terminal,
	output drs_pkg::drs_keys_t o_local_keys,
	output drs_pkg::drs_keys_t o_remote_keys,
	output drs_pkg::drs_link_cmd_t o_link_cmd
);
	timeunit 1ns;
	timeprecision 1ps;
	drs_keys_t lq = '0;
	drs_keys_t rq = '0;

	// contacts and link command are plain levels
	assign o_terminal = i_contacts;
	assign o_link_cmd = i_link_req;
	// a held key gives one press; posedge update avoids racing the bench
	assign o_local_keys = i_local_req & ~lq;
	assign o_remote_keys = i_remote_req & ~rq;

	// last key levels
	always @(posedge i_mclk) begin
		lq <= i_local_req;
		rq <= i_remote_req;
	end
endmodule // drs_far_side

// File: verif/drs_run_select_bench.sv
module drs_run_select_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import drs_pkg::*;
	logic clk = 0, rst_n = 0, zero = 1, neg = 0, fault = 0, rem = 0, wr = 0;
	logic [7:0] con = '0, term;
	logic [2:0] sel = '0, idx;
	logic [15:0] dat = '0, fcmd = '0, afrq = '0, frq;
	logic run, rev, blk, bad;
	drs_cfg_t cfg = '0;
	drs_keys_t lreq = '0, rreq = '0, lk, rk;
	drs_link_cmd_t lnk = '0, lc;
	int error_cnt = 0, compares = 0, seed = 3;
	int tab[$] = '{0, 1000, 2000, 3000, 3000, 2500, 2000, 1500};

	// ----------------------------------------
	// clock, design and far side
	// ----------------------------------------
	initial forever #2.5 clk = ~clk;

	drs_run_select uut (.i_mclk(clk), .i_rst_n(rst_n), .i_cfg(cfg), .i_terminal(term),
		.i_local_keys(lk), .i_remote_keys(rk), .i_remote_present(rem), .i_link_cmd(lc),
		.i_freq_cmd(fcmd), .i_analog_freq(afrq), .i_bipolar_negative(neg), .i_fault(fault),
		.i_at_zero_speed(zero), .i_step_wr(wr), .i_step_sel(sel), .i_step_data(dat),
		.o_run(run), .o_reverse(rev), .o_freq_ref(frq), .o_step_index(idx),
		.o_dir_blocked(blk), .o_link_cfg_bad(bad));
	drs_far_side u_far (.i_mclk(clk), .i_contacts(con), .i_local_req(lreq),
		.i_remote_req(rreq), .i_link_req(lnk), .o_terminal(term), .o_local_keys(lk),
		.o_remote_keys(rk), .o_link_cmd(lc));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic wait_n(int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic cmp_bit(string nm, logic e, logic g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s exp %b got %b", nm, e, g);
		end
	endtask

	task automatic cmp_val(string nm, int e, logic [15:0] g);
		compares++;
		if (g !== e[15:0]) begin
			error_cnt++;
			$display("wrong value %s exp %0d got %0d", nm, e, g);
		end
	endtask

	// model: two decisions plus a turn fit in 650 cycles
	task automatic expect_out(logic r, logic v, logic b);
		int i;
		int f;
		wait_n(650);
		i = con[7:5];
		f = i != 0 ? tab[i] : cfg.freq_source == FSRC_KEYPAD ? fcmd : afrq;
		cmp_bit("run", r, run);
		if (r)
			cmp_bit("reverse", v, rev);
		cmp_bit("blocked", b, blk);
		cmp_val("step", i, {13'h0, idx});
		cmp_val("freq", f, frq);
	endtask

	task automatic press(bit remote, bit stop);
		if (remote)
			rreq = {~stop, stop};
		else
			lreq = {~stop, stop};
		wait_n(2);
		lreq = '0;
		rreq = '0;
	endtask

	// model clamps like the table does; entry zero is not writable
	task automatic wr_step(logic [2:0] s, logic [15:0] d);
		sel = s;
		dat = d;
		wr = 1;
		wait_n(1);
		wr = 0;
		// one idle edge so back-to-back writes never re-raise the strobe at once
		wait_n(1);
		if (s != 0)
			tab[s] = d > 40000 ? 40000 : d;
	endtask

	task automatic do_reset();
		rst_n = 0;
		wait_n(6);
		rst_n = 1;
	endtask

	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ----------------------------------------
	// watchdog
	// ----------------------------------------
	initial begin
		repeat (60000) @(posedge clk);
		error_cnt++;
		finish_test();
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		cfg.input_function = {FUNC_STEP2, FUNC_STEP1, FUNC_STEP0, {3{5'h1F}}, FUNC_REV, FUNC_FWD};
		cfg.station_number = STATION_MIN;
		cfg.link_baud_index = BAUD_DEF;
		cfg.drive_mode = MODE_TWO_WIRE;
		fcmd = 16'({$random(seed)} % 40001);
		afrq = 16'({$random(seed)} % 40001);
		do_reset();
		// let the first decision end boot; a run contact on before it stays refused
		wait_n(250);
		for (int i = 0; i < 8; i++) begin
			con = {i[2:0], 5'h01};
			expect_out(1, 0, 0);
		end
		con = 8'h03;
		expect_out(0, 0, 0);
		con = 8'h02;
		expect_out(1, 1, 0);
		con = 8'h00;
		expect_out(0, 0, 0);
		cfg.drive_mode = MODE_RUN_DIR;
		con = 8'h01;
		expect_out(1, 0, 0);
		con = 8'h03;
		expect_out(1, 1, 0);
		$display("test terminals done");
		cfg.drive_mode = MODE_TWO_WIRE;
		cfg.run_disable = RUN_DIS_REV;
		con = 8'h02;
		expect_out(0, 0, 1);
		con = 8'h01;
		expect_out(1, 0, 0);
		cfg.run_disable = RUN_DIS_FWD;
		expect_out(0, 0, 1);
		con = 8'h00;
		cfg.run_disable = 2'h0;
		$display("test disable done");
		cfg.drive_mode = MODE_KEYPAD;
		cfg.keypad_direction_select = DIR_REV;
		press(0, 0);
		expect_out(1, 1, 0);
		rem = 1;
		press(0, 1);
		expect_out(1, 1, 0);
		press(1, 1);
		expect_out(0, 0, 0);
		rem = 0;
		cfg.keypad_direction_select = DIR_FWD;
		press(0, 0);
		expect_out(1, 0, 0);
		$display("test keypad done");
		cfg.drive_mode = MODE_LINK;
		lnk = 2'b11;
		expect_out(1, 1, 0);
		cfg.station_number = 8'hFB;
		expect_out(0, 0, 0);
		cmp_bit("link bad", 1, bad);
		cfg.station_number = STATION_MIN;
		lnk = 2'b00;
		$display("test link done");
		cfg.drive_mode = MODE_TWO_WIRE;
		cfg.freq_source = FSRC_BIPOLAR;
		con = 8'h01;
		expect_out(1, 0, 0);
		zero = 0;
		neg = 1;
		expect_out(0, 0, 0);
		zero = 1;
		expect_out(1, 1, 0);
		neg = 0;
		cfg.freq_source = FSRC_KEYPAD;
		$display("test bipolar done");
		wr_step(3, 16'hFFFF);
		wr_step(4, 16'({$random(seed)} % 40001));
		wr_step(0, 16'h1234);
		con = {3'h3, 5'h01};
		expect_out(1, 0, 0);
		con = {3'h4, 5'h01};
		expect_out(1, 0, 0);
		con = 8'h01;
		$display("test table done");
		fault = 1;
		expect_out(0, 0, 0);
		cfg.restart_after_fault_clear = 1;
		fault = 0;
		expect_out(1, 0, 0);
		cfg.restart_after_fault_clear = 0;
		fault = 1;
		wait_n(450);
		fault = 0;
		expect_out(0, 0, 0);
		cfg.power_up_autostart = 1;
		do_reset();
		expect_out(1, 0, 0);
		$display("test restart done");
		finish_test();
	end
endmodule // drs_run_select_bench
